//--- tb_watchdog_interval_timer.sv
// self-checking bench of the watchdog interval timer
`timescale 1ns/1ps
module tb_watchdog_interval_timer;
  reg clk, rstn, wr_en, rd_en, stop_mode, sub_clk_cpu, wdog_irq_mask, clr;
  reg [15:0] addr;
  reg [7:0] wr_data, wr_bit_mask;
  wire [7:0] rd_data;
  wire flag, irq, nmi, srst, ovf;
  integer fails, cmp_count, cyc, n;
  wdit_timer dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wr_en(wr_en), .wr_data(wr_data),
    .wr_bit_mask(wr_bit_mask), .rd_en(rd_en), .rd_data(rd_data), .stop_mode(stop_mode),
    .sub_clk_cpu(sub_clk_cpu), .wdog_pending_flag(flag), .wdog_irq_mask(wdog_irq_mask),
    .wdog_interval_irq(irq), .wdog_nmi(nmi), .wdog_sys_reset(srst), .overflow_evt(ovf));
  wdit_host_model host_u (.clk(clk), .rstn(rstn), .ovf(ovf), .clr(clr), .flag(flag));
  task give_verdict;
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task ck(input [31:0] g, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      $display("Error t=%0t got %h exp %h", $time, g, e);
      fails = fails + 1;
    end
  endtask
  // register cycles
  task wr(input [15:0] a, input [7:0] d, input [7:0] m);
    @(posedge clk) {addr, wr_data, wr_bit_mask, wr_en} <= {a, d, m, 1'b1};
    @(posedge clk) wr_en <= 1'b0;
  endtask
  task rd(input [15:0] a, input [7:0] e);
    @(posedge clk) {addr, rd_en} <= {a, 1'b1};
    @(posedge clk) rd_en <= 1'b0;
    #1 ck(rd_data, e);
  endtask
  // cycles until a selected event, bounded
  task wt(input [2:0] m, input integer lim);
    n = 0;
    do begin
      @(posedge clk);
      #1 n = n + 1;
    end while (!(|({srst, nmi, irq} & m)) && n < lim);
  endtask
  task t_regs;
    rd(16'hff42, 8'h00);
    rd(16'hfff9, 8'h00);
    wr(16'hff42, 8'hff, 8'hff);
    rd(16'hff42, 8'h07);
    wr(16'hff42, 8'h00, 8'hff);
    rd(16'h1234, 8'h00);
  endtask
  task t_interval;
    wr(16'hfff9, 8'h88, 8'hff);
    wt(3'h1, 2100);
    ck(n >= 2020 && n <= 2060, 1);
    wr(16'hfff9, 8'h00, 8'h80);
    rd(16'hfff9, 8'h88);
    wt(3'h1, 2100);
    wt(3'h1, 2100);
    ck(n, 2048);
    @(posedge clk) wdog_irq_mask <= 1'b1;
    wt(3'h1, 2100);
    ck(n, 2100);
    @(posedge clk) wdog_irq_mask <= 1'b0;
  endtask
  task t_watchdog;
    ck(flag, 1);
    wr(16'hfff9, 8'h10, 8'h10);
    #1 ck(nmi, 1);
    @(posedge clk) #1 ck(nmi, 0);
    wr(16'hfff9, 8'h00, 8'hff);
    rd(16'hfff9, 8'h98);
    wr(16'hfff9, 8'h80, 8'h80);
    {stop_mode, sub_clk_cpu} <= 2'b10;
    wt(3'h4, 2500);
    ck(n, 2500);
    @(posedge clk) {stop_mode, sub_clk_cpu} <= 2'b01;
    wt(3'h4, 2500);
    ck(n, 2500);
    @(posedge clk) sub_clk_cpu <= 1'b0;
    repeat (3) begin
      wr(16'hfff9, 8'h80, 8'h80);
      wt(3'h4, 1500);
      ck(n, 1500);
    end
    wt(3'h4, 2100);
    ck(srst, 1);
  endtask
  task t_nmi;
    @(posedge clk) {rstn, clr} <= 2'b01;
    @(posedge clk) {rstn, clr} <= 2'b10;
    wr(16'hfff9, 8'h90, 8'hff);
    #1 ck(nmi, 0);
    wt(3'h6, 2100);
    ck({srst, nmi}, 2'b01);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      give_verdict;
    end
  end
  initial begin
    {rstn, wr_en, rd_en, stop_mode, sub_clk_cpu, wdog_irq_mask, clr} = 7'h00;
    {addr, wr_data, wr_bit_mask} = 32'h0;
    {fails, cmp_count, cyc, n} = 128'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_regs;
    t_interval;
    t_watchdog;
    t_nmi;
    give_verdict;
  end
endmodule // tb_watchdog_interval_timer

//--- wdit_chk.sv
// port assertions of the watchdog interval timer
`timescale 1ns/1ps
module wdit_chk (
  input wire clk,
  input wire rstn,
  input wire [15:0] addr,
  input wire wr_en,
  input wire [7:0] wr_data,
  input wire [7:0] wr_bit_mask,
  input wire rd_en,
  input wire [7:0] rd_data,
  input wire stop_mode,
  input wire sub_clk_cpu,
  input wire wdog_pending_flag,
  input wire wdog_irq_mask,
  input wire wdog_interval_irq,
  input wire wdog_nmi,
  input wire wdog_sys_reset,
  input wire overflow_evt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire mw = wr_en && addr == 16'hfff9;
  reg [11:0] gap_r;
  reg mhi_r;
  // cycles since restart or overflow; high mode bit seen
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_r <= 12'h000;
      mhi_r <= 1'b0;
    end else begin
      gap_r <= (overflow_evt || (mw && wr_data[7] && wr_bit_mask[7])) ? 12'h000 :
        gap_r + {11'h000, gap_r != 12'hfff};
      mhi_r <= mhi_r | (mw & wr_data[4] & wr_bit_mask[4]);
    end
  end
  sequence halt_s; (stop_mode || sub_clk_cpu) [*3]; endsequence
  sequence mask_s; wdog_irq_mask [*3]; endsequence
  unmap_read_a: assert property (rd_en && addr != 16'hff42 && addr != 16'hfff9
    |=> rd_data == 8'h00) else $error("unmapped read");
  cs_bits_a: assert property (rd_en && addr == 16'hff42 |=> rd_data[7:3] == 5'h00)
    else $error("clock select bits");
  mode_bits_a: assert property (rd_en && mw == 1'b0 && addr == 16'hfff9
    |=> (rd_data & 8'h67) == 8'h00) else $error("mode bits");
  irq_excl_a: assert property (!(wdog_interval_irq && wdog_sys_reset))
    else $error("two actions");
  halt_count_a: assert property (halt_s |-> !overflow_evt) else $error("count while stopped");
  mask_gate_a: assert property (mask_s |-> !wdog_interval_irq) else $error("masked irq");
  ovf_gap_a: assert property (overflow_evt |-> gap_r >= 12'd2000)
    else $error("overflow early");
  pend_nmi_a: assert property (mw && wr_data[4] && wr_bit_mask[4] && !mhi_r &&
    wdog_pending_flag |-> ##[1:3] wdog_nmi) else $error("no nmi");
endmodule // wdit_chk
bind wdit_timer wdit_chk chk_u (.*);

//--- wdit_host_model.sv
// pending flag model of the interrupt controller
`timescale 1ns/1ps
module wdit_host_model (
  input wire clk, // clock
  input wire rstn, // reset
  input wire ovf, // overflow
  input wire clr, // clear
  output reg flag // pending
);
  // set on overflow, cleared by software
  always @(posedge clk or negedge rstn)
    if (!rstn) flag <= 1'b0;
    else if (clr) flag <= 1'b0;
    else if (ovf) flag <= 1'b1;
endmodule // wdit_host_model

//--- wdit_prescaler.v
// prescaler, advanced only while run_en is high, giving divide-by 16/64/256/1024 count enables
`timescale 1ns/1ps
`include "wdit_regs.vh"
module wdit_prescaler #(
  parameter PRE_W = `WDIT_PRE_W
) (
  input wire clk, // main clock
  input wire rstn, // async reset, active low
  input wire run_en, // advance prescaler
  input wire [2:0] sel, // clock select code
  output reg tick // one-cycle count enable
);
  reg [PRE_W-1:0] pre_r;
  reg [PRE_W-1:0] pre_nxt;
  reg tick_nxt;

  // tick when the chosen low bits all wrap; never cleared by restart
  always @* begin
    pre_nxt = pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
    tick_nxt = 1'b0;
    if (run_en) begin
      case (sel)
        `WDIT_SEL_DIV16: tick_nxt = &pre_r[`WDIT_TAP16:0];
        `WDIT_SEL_DIV64: tick_nxt = &pre_r[`WDIT_TAP64:0];
        `WDIT_SEL_DIV256: tick_nxt = &pre_r[`WDIT_TAP256:0];
        `WDIT_SEL_DIV1024: tick_nxt = &pre_r[`WDIT_TAP1024:0];
        default: tick_nxt = 1'b0;
      endcase
    end
  end

  // prescaler state
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= {PRE_W{1'b0}};
      tick <= 1'b0;
    end else begin
      if (run_en) begin
        pre_r <= pre_nxt;
      end
      tick <= tick_nxt;
    end
  end
endmodule // wdit_prescaler

//--- wdit_regs.vh
// register map, field positions and timing constants of the watchdog interval timer
`ifndef WDIT_REGS_VH
`define WDIT_REGS_VH
`define WDIT_ADDR_W 16
`define WDIT_CS_ADDR 16'hff42
`define WDIT_MODE_ADDR 16'hfff9
`define WDIT_RESET_VAL 8'h00
`define WDIT_CS_MASK 8'h07
`define WDIT_MODE_MASK 8'h98
`define WDIT_RUN_BIT 7
`define WDIT_MHI_BIT 4
`define WDIT_MLO_BIT 3
`define WDIT_SEL_LO 0
`define WDIT_SEL_HI 2
`define WDIT_PRE_W 10
`define WDIT_CNT_W 7
`define WDIT_CNT_MAX 7'h7f
`define WDIT_SEL_DIV16 3'h0
`define WDIT_SEL_DIV64 3'h2
`define WDIT_SEL_DIV256 3'h4
`define WDIT_SEL_DIV1024 3'h6
`define WDIT_TAP16 3
`define WDIT_TAP64 5
`define WDIT_TAP256 7
`define WDIT_TAP1024 9
`endif

//--- wdit_timer.v
// watchdog / interval timer top with its two control registers
`timescale 1ns/1ps
`include "wdit_regs.vh"
module wdit_timer (
  input wire clk, // main system clock
  input wire rstn, // async reset, active low
  input wire [15:0] addr, // register address
  input wire wr_en, // write strobe
  input wire [7:0] wr_data, // write data
  input wire [7:0] wr_bit_mask, // bits written to the mode register; all ones for byte access
  input wire rd_en, // read strobe
  output reg [7:0] rd_data, // read data
  input wire stop_mode, // cpu in stop standby
  input wire sub_clk_cpu, // subsystem clock drives the cpu
  input wire wdog_pending_flag, // pending flag from interrupt flag register
  input wire wdog_irq_mask, // interval interrupt mask
  output reg wdog_interval_irq, // maskable interrupt pulse
  output reg wdog_nmi, // non-maskable interrupt pulse
  output reg wdog_sys_reset, // system reset request pulse
  output reg overflow_evt // raw overflow pulse, sets the pending flag
);
  // overflow action codes of the two mode bits
  localparam [1:0] ACT_STOP = 2'h0;
  localparam [1:0] ACT_IVL = 2'h1;
  localparam [1:0] ACT_NMI = 2'h2;
  localparam [1:0] ACT_RESET = 2'h3;

  // register state and next values
  reg [7:0] cs_r;
  reg run_r;
  reg mode_high_bit;
  reg mode_low_bit;
  reg [`WDIT_CNT_W-1:0] cnt_r;
  reg [7:0] mode_wr;
  reg [7:0] rd_nxt;
  reg pend_s1_r;
  reg pend_r;
  reg [7:0] cs_nxt;
  reg run_nxt;
  reg mhi_nxt;
  reg mlo_nxt;
  reg [`WDIT_CNT_W-1:0] cnt_nxt;
  reg evt_nxt;
  reg irq_nxt;
  reg nmi_nxt;
  reg srst_nxt;
  // decode and event wires
  wire tick;
  wire [2:0] clk_sel;
  wire [7:0] mode_rd;
  wire cs_hit;
  wire mode_hit;
  wire counting;
  wire run_wr;
  wire ovf;

  assign cs_hit = wr_en && (addr == `WDIT_CS_ADDR);
  assign mode_hit = wr_en && (addr == `WDIT_MODE_ADDR);
  // mode register image and clock select field
  assign mode_rd = {run_r, 2'b00, mode_high_bit, mode_low_bit, 3'b000};
  assign clk_sel = cs_r[`WDIT_SEL_HI:`WDIT_SEL_LO];
  // bit writes merge into current mode value
  always @* begin
    mode_wr = (mode_rd & ~wr_bit_mask) | (wr_data & wr_bit_mask);
  end
  assign run_wr = mode_hit && wr_bit_mask[`WDIT_RUN_BIT] && wr_data[`WDIT_RUN_BIT];
  assign counting = run_r && !stop_mode && !sub_clk_cpu;
  assign ovf = counting && tick && (cnt_r == `WDIT_CNT_MAX);

  // prescaler keeps running across restarts
  wdit_prescaler #(
    .PRE_W(`WDIT_PRE_W)
  ) u_pre (
    .clk(clk),
    .rstn(rstn),
    .run_en(counting),
    .sel(clk_sel),
    .tick(tick)
  );

  // pending flag comes from the interrupt controller; synchronise it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_s1_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      pend_s1_r <= wdog_pending_flag;
      pend_r <= pend_s1_r;
    end
  end

  // next control values; run and mode bits can only be set by software
  always @* begin
    cs_nxt = cs_r;
    run_nxt = run_r;
    mhi_nxt = mode_high_bit;
    mlo_nxt = mode_low_bit;
    if (cs_hit) begin
      cs_nxt = wr_data & `WDIT_CS_MASK;
    end
    if (mode_hit) begin
      run_nxt = run_r | mode_wr[`WDIT_RUN_BIT];
      mhi_nxt = mode_high_bit | mode_wr[`WDIT_MHI_BIT];
      mlo_nxt = mode_low_bit | mode_wr[`WDIT_MLO_BIT];
    end
  end

  // control registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_r <= `WDIT_RESET_VAL;
      run_r <= 1'b0;
      mode_high_bit <= 1'b0;
      mode_low_bit <= 1'b0;
    end else begin
      cs_r <= cs_nxt;
      run_r <= run_nxt;
      mode_high_bit <= mhi_nxt;
      mode_low_bit <= mlo_nxt;
    end
  end

  // counter next value, cleared by every run write
  always @* begin
    cnt_nxt = cnt_r;
    if (run_wr) begin
      cnt_nxt = {`WDIT_CNT_W{1'b0}};
    end else if (counting && tick) begin
      cnt_nxt = cnt_r + {{(`WDIT_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // counter register
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= {`WDIT_CNT_W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // overflow action by mode; a run write in the same cycle wins
  always @* begin
    evt_nxt = ovf && !run_wr;
    irq_nxt = 1'b0;
    nmi_nxt = 1'b0;
    srst_nxt = 1'b0;
    case ({mode_high_bit, mode_low_bit})
      ACT_STOP: begin
        irq_nxt = 1'b0;
      end
      ACT_IVL: begin
        irq_nxt = evt_nxt && !wdog_irq_mask;
      end
      ACT_NMI: begin
        nmi_nxt = evt_nxt;
      end
      ACT_RESET: begin
        srst_nxt = evt_nxt;
      end
      default: begin
        srst_nxt = 1'b0;
      end
    endcase
    if (mode_hit && !mode_high_bit && mode_wr[`WDIT_MHI_BIT] && pend_r) begin
      nmi_nxt = 1'b1;
    end
  end

  // overflow action outputs, one-cycle pulses
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdog_interval_irq <= 1'b0;
      wdog_nmi <= 1'b0;
      wdog_sys_reset <= 1'b0;
      overflow_evt <= 1'b0;
    end else begin
      overflow_evt <= evt_nxt;
      wdog_interval_irq <= irq_nxt;
      wdog_nmi <= nmi_nxt;
      wdog_sys_reset <= srst_nxt;
    end
  end

  // register readback, unused bits zero
  always @* begin
    rd_nxt = `WDIT_RESET_VAL;
    if (addr == `WDIT_CS_ADDR) begin
      rd_nxt = cs_r;
    end else if (addr == `WDIT_MODE_ADDR) begin
      rd_nxt = mode_rd;
    end else begin
      rd_nxt = `WDIT_RESET_VAL;
    end
  end

  // read data register, holds between reads
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `WDIT_RESET_VAL;
    end else if (rd_en) begin
      rd_data <= rd_nxt;
    end
  end
endmodule // wdit_timer
